// *** pkg/fbp_pkg.sv ***
// shared constants, types and carriers of the block-erase flash controller
package fbp_pkg;

	// ------------------------------------------------------------
	// array geometry
	// ------------------------------------------------------------
	localparam int unsigned FLASH_BYTES = 131072;
	localparam int unsigned BLOCK_BYTES = 1024;
	localparam int unsigned REGION_BYTES = 2048;
	localparam int unsigned WORD_BYTES = 4;
	localparam int unsigned DATA_W = 32;

	localparam int unsigned ADDR_W = $clog2(FLASH_BYTES);
	localparam int unsigned WORD_LSB = $clog2(WORD_BYTES);
	localparam int unsigned BLOCK_LSB = $clog2(BLOCK_BYTES);
	localparam int unsigned REGION_LSB = $clog2(REGION_BYTES);

	localparam int unsigned WORD_COUNT = FLASH_BYTES / WORD_BYTES;
	localparam int unsigned WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
	localparam int unsigned REGION_COUNT = FLASH_BYTES / REGION_BYTES;

	localparam int unsigned WIDX_W = ADDR_W - WORD_LSB;
	localparam int unsigned WOFF_W = BLOCK_LSB - WORD_LSB;
	localparam int unsigned BIDX_W = ADDR_W - BLOCK_LSB;
	localparam int unsigned RIDX_W = ADDR_W - REGION_LSB;

	// ------------------------------------------------------------
	// data values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [DATA_W-1:0] BLANK_DATA = 32'h00000000;
	localparam logic [WOFF_W-1:0] LAST_WOFF = WOFF_W'(WORDS_PER_BLOCK - 1);
	localparam logic [WOFF_W-1:0] FIRST_WOFF = 8'h00;

	// ------------------------------------------------------------
	// operations, states and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FBP_OP_FETCH,
		FBP_OP_DATA_READ,
		FBP_OP_DEBUG_READ,
		FBP_OP_PROGRAM,
		FBP_OP_ERASE
	} fbp_op_e;

	typedef enum logic {
		FBP_ST_IDLE,
		FBP_ST_ERASE
	} fbp_state_e;

	typedef struct packed {
		fbp_op_e op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fbp_req_s;

	typedef struct packed {
		fbp_op_e op;
		logic denied;
		logic [DATA_W-1:0] rdata;
	} fbp_rsp_s;

endpackage

// *** rtl/fbp_prot_check.sv ***
// protection decision for one request against its 2 KB region
module fbp_prot_check
	import fbp_pkg::*;
(
	// request under test
	input wire fbp_op_e op,
	input wire logic [ADDR_W-1:0] addr,
	// per-region settings
	input wire logic [REGION_COUNT-1:0] region_read_only,
	input wire logic [REGION_COUNT-1:0] region_exec_only,
	// decision
	output logic allowed
);

	logic [RIDX_W-1:0] region;
	logic ro;
	logic xo;
	logic modify;
	logic fetch;

	// ------------------------------------------------------------
	// region lookup
	// ------------------------------------------------------------
	// two adjacent 1 KB blocks share one setting
	assign region = addr[ADDR_W-1:REGION_LSB];
	assign ro = region_read_only[region];
	assign xo = region_exec_only[region];
	assign modify = (op == FBP_OP_PROGRAM) || (op == FBP_OP_ERASE);
	assign fetch = (op == FBP_OP_FETCH);

	// ------------------------------------------------------------
	// decision
	// ------------------------------------------------------------
	// both marks set: the stricter execute-only reading wins
	always_comb begin
		if (modify) begin
			allowed = !(ro || xo);
		end else if (fetch) begin
			allowed = 1'b1;
		end else begin
			allowed = !xo;
		end
	end

endmodule

// *** rtl/fbp_flash_ctrl.sv ***
// flash array controller with 1 KB block erase and 2 KB region protection
// Function
// - 128 KB nonvolatile array behind the controller
// - each 1 KB block erases on its own
// - erased block reads as all ones
// - protection set per 2 KB block pair
// - region marked read-only or execute-only
// - read-only region refuses erase and program
// - execute-only: no modify, fetch reads only
module fbp_flash_ctrl
	import fbp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// request from fetch, data bus and debugger
	input wire logic req_valid,
	output logic req_ready,
	input wire fbp_req_s req,
	// response
	output logic rsp_valid,
	output fbp_rsp_s rsp,
	// protection settings
	input wire logic [REGION_COUNT-1:0] region_read_only,
	input wire logic [REGION_COUNT-1:0] region_exec_only,
	// status
	output logic busy
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	// no reset on the array: its contents must survive a reset
	logic [DATA_W-1:0] mem [WORD_COUNT];

	logic mem_we;
	logic [WIDX_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	fbp_state_e state;
	fbp_state_e next_state;
	logic [BIDX_W-1:0] erase_block;
	logic [BIDX_W-1:0] next_erase_block;
	logic [WOFF_W-1:0] erase_off;
	logic [WOFF_W-1:0] next_erase_off;
	logic next_rsp_valid;
	fbp_rsp_s next_rsp;

	// ------------------------------------------------------------
	// request view
	// ------------------------------------------------------------
	logic take;
	logic allowed;
	logic [WIDX_W-1:0] req_widx;
	logic [BIDX_W-1:0] req_block;
	logic [DATA_W-1:0] cur_word;
	logic [WIDX_W-1:0] erase_widx;

	// ------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------
	logic is_read;
	logic is_prog;
	logic is_erase;
	logic take_deny;
	logic take_read;
	logic take_prog;
	logic take_erase;
	logic erase_last;

	fbp_prot_check u_prot (
		.op(req.op),
		.addr(req.addr),
		.region_read_only(region_read_only),
		.region_exec_only(region_exec_only),
		.allowed(allowed)
	);

	assign req_ready = (state == FBP_ST_IDLE);
	assign take = req_valid && req_ready;
	assign req_widx = req.addr[ADDR_W-1:WORD_LSB];
	assign req_block = req.addr[ADDR_W-1:BLOCK_LSB];
	// combinational array read; the word is registered into rsp
	assign cur_word = mem[req_widx];
	assign busy = (state == FBP_ST_ERASE);

	// class of the request, independent of its protection
	always_comb begin
		is_read = 1'b0;
		is_prog = 1'b0;
		is_erase = 1'b0;
		unique case (req.op)
			FBP_OP_FETCH, FBP_OP_DATA_READ, FBP_OP_DEBUG_READ: begin
				is_read = 1'b1;
			end
			FBP_OP_PROGRAM: begin
				is_prog = 1'b1;
			end
			FBP_OP_ERASE: begin
				is_erase = 1'b1;
			end
			default: begin
				// spare codes fall in no class and are refused below
			end
		endcase
	end

	// a refusal writes nothing and answers denied with blank data
	assign take_deny = take && !(allowed && (is_read || is_prog || is_erase));
	assign take_read = take && allowed && is_read;
	assign take_prog = take && allowed && is_prog;
	assign take_erase = take && allowed && is_erase;
	assign erase_last = (erase_off == LAST_WOFF);
	assign erase_widx = {erase_block, erase_off};

	// ------------------------------------------------------------
	// erase sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_erase_block = erase_block;
		next_erase_off = erase_off;
		unique case (state)
			FBP_ST_IDLE: begin
				if (take_erase) begin
					next_state = FBP_ST_ERASE;
					// block index kept here; the request lines may move on
					next_erase_block = req_block;
					next_erase_off = FIRST_WOFF;
				end
			end
			FBP_ST_ERASE: begin
				// one word per cycle, never past the chosen block
				next_erase_off = erase_off + 1'b1;
				if (erase_last) begin
					next_state = FBP_ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= FBP_ST_IDLE;
			erase_block <= '0;
			erase_off <= '0;
		end else begin
			state <= next_state;
			erase_block <= next_erase_block;
			erase_off <= next_erase_off;
		end
	end

	// ------------------------------------------------------------
	// response
	// ------------------------------------------------------------
	// fields hold between pulses, except that an erase take loads them before its pulse; only the valid strobe drops
	always_comb begin
		next_rsp_valid = 1'b0;
		next_rsp = rsp;
		if (take) begin
			next_rsp.op = req.op;
			next_rsp.denied = 1'b0;
			next_rsp.rdata = BLANK_DATA;
		end
		if (take_deny) begin
			next_rsp_valid = 1'b1;
			next_rsp.denied = 1'b1;
			next_rsp.rdata = BLANK_DATA;
		end else if (take_read) begin
			next_rsp_valid = 1'b1;
			next_rsp.rdata = cur_word;
		end else if (take_prog) begin
			next_rsp_valid = 1'b1;
		end else if (busy && erase_last) begin
			// an erase answers only after its last word is written
			next_rsp_valid = 1'b1;
			next_rsp.denied = 1'b0;
			next_rsp.rdata = BLANK_DATA;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp <= '0;
		end else begin
			rsp_valid <= next_rsp_valid;
			rsp <= next_rsp;
		end
	end

	// ------------------------------------------------------------
	// array write port
	// ------------------------------------------------------------
	// the erase walk owns the port; no request is taken meanwhile
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = req_widx;
		mem_wdata = ERASED_WORD;
		if (busy) begin
			mem_we = 1'b1;
			mem_waddr = erase_widx;
			mem_wdata = ERASED_WORD;
		end else if (take_prog) begin
			// programming only clears bits; ones need an erase
			mem_we = 1'b1;
			mem_waddr = req_widx;
			mem_wdata = cur_word & req.wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

endmodule

// *** sim/fbp_flash_ctrl_assertions.sv ***
// concurrent checks on the flash controller ports
module fbp_chk
	import fbp_pkg::*;
(
	// watched ports
	input wire logic core_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire fbp_req_s req,
	input wire logic rsp_valid,
	input wire fbp_rsp_s rsp,
	input wire logic [REGION_COUNT-1:0] region_read_only,
	input wire logic [REGION_COUNT-1:0] region_exec_only,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire logic take = req_valid && req_ready;
	wire logic [RIDX_W-1:0] rg = req.addr[ADDR_W-1:REGION_LSB];
	wire logic xo = region_exec_only[rg];
	wire logic lock = region_read_only[rg] || xo;
	wire logic peek = req.op inside {FBP_OP_DATA_READ, FBP_OP_DEBUG_READ};
	wire logic modify = req.op inside {FBP_OP_PROGRAM, FBP_OP_ERASE};
	// busy cycles already past in the current stretch, 0 on its first busy cycle
	logic [BLOCK_LSB-WORD_LSB:0] busy_run;
	always_ff @(posedge core_clk) begin
		if (reset || !busy) begin
			busy_run <= '0;
		end else begin
			busy_run <= busy_run + 1'b1;
		end
	end
	sequence s_erase_go;
		take && req.op == FBP_OP_ERASE && !lock;
	endsequence
	// a short walk would leave the tail of the block unerased
	sequence s_erase_walk;
		##1 busy ##255 busy ##1 (rsp_valid && !busy && !rsp.denied);
	endsequence
	a_erase_walk: assert property (s_erase_go |-> s_erase_walk)
		else $error("erase walk length wrong");
	a_ready_busy: assert property (req_ready == !busy)
		else $error("ready while busy");
	a_busy_bound: assert property (busy |-> busy_run < WORDS_PER_BLOCK)
		else $error("erase walk runs past its block");
	a_read_ret: assert property (take && !modify |=> rsp_valid && rsp.op == $past(req.op))
		else $error("read answer missing");
	a_prog_once: assert property (take && req.op == FBP_OP_PROGRAM && !lock |=> rsp_valid && !rsp.denied)
		else $error("program not accepted");
	a_mod_lock: assert property (take && modify && lock |=> rsp_valid && rsp.denied && !busy)
		else $error("locked region modified");
	a_xo_hide: assert property (take && peek && xo |=> rsp.denied)
		else $error("execute-only data leaked");
	a_ro_read: assert property (take && peek && !xo |=> !rsp.denied)
		else $error("readable region denied");
	a_fetch_open: assert property (take && req.op == FBP_OP_FETCH |=> !rsp.denied)
		else $error("fetch denied");
	a_deny_blank: assert property (rsp_valid && rsp.denied |-> rsp.rdata == BLANK_DATA)
		else $error("denied answer carries data");
endmodule

// *** sim/fbp_host_model.sv ***
// requester model for instruction fetch, data bus and debugger
module fbp_host_model
	import fbp_pkg::*;
(
	// request side
	input wire logic core_clk,
	output logic req_valid,
	input wire logic req_ready,
	output fbp_req_s req
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// scramble the idle bus so stale values never look like a request
	task automatic issue(fbp_op_e op, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] wd, int gap);
		repeat (gap + 1) @(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{op, a, wd};
		do @(posedge core_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req <= ~req;
	endtask
endmodule

// *** sim/flash_block_erase_protect_tb.sv ***
// self-checking bench for the block-erase flash controller
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD %0t wrong response", $time); end end
module flash_block_erase_protect_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fbp_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, req_valid, req_ready, rsp_valid, busy;
	fbp_req_s req;
	fbp_rsp_s rsp;
	logic [REGION_COUNT-1:0] region_read_only = '0, region_exec_only = '0;
	logic [31:0] lfsr = 32'hD251, p;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	fbp_rsp_s exp_q[$];
	always #2.5 core_clk = ~core_clk;
	fbp_flash_ctrl dut (
		.core_clk(core_clk),
		.reset(reset),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.req(req),
		.rsp_valid(rsp_valid),
		.rsp(rsp),
		.region_read_only(region_read_only),
		.region_exec_only(region_exec_only),
		.busy(busy)
	);
	fbp_host_model host (.core_clk, .req_valid, .req_ready, .req);
	function automatic logic [31:0] step(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic go(fbp_op_e op, int b, int w, logic [31:0] wd, logic den, logic [31:0] rd);
		exp_q.push_back('{op, den, rd});
		host.issue(op, ADDR_W'(b * BLOCK_BYTES + w * WORD_BYTES), wd, int'(lfsr[1:0]));
		lfsr = step(lfsr);
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (rsp_valid === 1'b1)
			`CHK(rsp, exp_q.pop_front())
		if (cyc > 6000) begin
			n_mismatch++;
			$display("BAD %0t run timed out", $time);
			conclude();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		for (int b = 0; b < 5; b++) go(FBP_OP_ERASE, b, 0, 0, 1'b0, BLANK_DATA);
		go(FBP_OP_FETCH, 0, 255, 0, 1'b0, ERASED_WORD);
		p = lfsr;
		go(FBP_OP_PROGRAM, 1, 7, p, 1'b0, BLANK_DATA);
		p = p & lfsr;
		go(FBP_OP_PROGRAM, 1, 7, lfsr, 1'b0, BLANK_DATA);
		go(FBP_OP_ERASE, 0, 0, 0, 1'b0, BLANK_DATA);
		go(FBP_OP_DATA_READ, 1, 7, 0, 1'b0, p);
		$display("test erase done");
		region_read_only <= 64'h1;
		region_exec_only <= 64'h2;
		for (int r = 0; r < 2; r++)
			for (int o = 0; o < 5; o++)
				go(fbp_op_e'(o), 2 * r + 1, r ? 9 : 7, lfsr, o > 2 || (r && o),
					(o > 2 || (r && o)) ? BLANK_DATA : (r ? ERASED_WORD : p));
		go(FBP_OP_ERASE, 4, 0, 0, 1'b0, BLANK_DATA);
		region_read_only <= '0;
		region_exec_only <= '0;
		go(fbp_op_e'(5), 4, 0, 0, 1'b1, BLANK_DATA);
		go(FBP_OP_DEBUG_READ, 1, 7, 0, 1'b0, p);
		go(FBP_OP_DATA_READ, 3, 9, 0, 1'b0, ERASED_WORD);
		$display("test protect done");
		for (int i = 0; i < 9 && exp_q.size() > 0; i++) @(posedge core_clk);
		conclude();
	end
	task automatic conclude();
		if (exp_q.size() != 0) begin
			n_mismatch++;
			$display("BAD %0t response missing", $time);
		end
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
endmodule

bind fbp_flash_ctrl fbp_chk u_chk (
	.core_clk(core_clk),
	.reset(reset),
	.req_valid(req_valid),
	.req_ready(req_ready),
	.req(req),
	.rsp_valid(rsp_valid),
	.rsp(rsp),
	.region_read_only(region_read_only),
	.region_exec_only(region_exec_only),
	.busy(busy)
);
